// ==== src/mcs_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module mcs_top
    import mcs_pkg::*;
#(
    parameter logic [CNT_W-1:0] ENTRY_CYC = ENTRY_LIMIT
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Master clock from the host, sampled as a level
    input wire logic i_mclk,
    // Host write of the volume-update bit, one-cycle pulse
    input wire logic i_vol_update,
    // Converter control
    output mcs_ctl_t o_ctl,
    output logic o_saving
);
    logic edge_w;
    mcs_state_t state_r, state_nxt;
    logic [CNT_W-1:0] idle_r, idle_nxt;
    mcs_ctl_t ctl_r, ctl_nxt;
    logic saving_r, saving_nxt;

    mcs_edge u_edge (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_lvl(i_mclk),
        .o_edge(edge_w)
    );

    // Idle counter; 2 us at 40 MHz sits at the lower end of the 2-10 us window
    always_comb begin
        idle_nxt = idle_r;
        if (edge_w) begin
            idle_nxt = CNT_ZERO;
        end else if (idle_r != ENTRY_CYC) begin
            idle_nxt = idle_r + CNT_ONE;
        end
    end

    // State and outputs; register file lives elsewhere and is never reset
    // here, so contents survive the stop
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            MCS_RUN: begin
                if (!edge_w && idle_r == ENTRY_CYC - CNT_ONE) begin
                    state_nxt = MCS_SAVE;
                end
            end
            MCS_SAVE: begin
                if (edge_w) begin
                    state_nxt = MCS_HOLDVOL;
                end
            end
            MCS_HOLDVOL: begin
                if (!edge_w && idle_r == ENTRY_CYC - CNT_ONE) begin
                    state_nxt = MCS_SAVE;
                end else if (i_vol_update) begin
                    state_nxt = MCS_RUN;
                end
            end
            default: state_nxt = MCS_RUN;
        endcase
        ctl_nxt.ch_power = (state_nxt == MCS_SAVE) ? CH_ALL_OFF
                                                   : CH_ALL_ON;
        ctl_nxt.filt_rst = (state_nxt == MCS_SAVE);
        ctl_nxt.vol_apply = (state_nxt == MCS_RUN);
        saving_nxt = (state_nxt == MCS_SAVE);
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_r <= MCS_RUN;
            idle_r <= CNT_ZERO;
            ctl_r <= '{ch_power: CH_ALL_ON, filt_rst: 1'b0, vol_apply: 1'b1};
            saving_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            idle_r <= idle_nxt;
            ctl_r <= ctl_nxt;
            saving_r <= saving_nxt;
        end
    end

    assign o_ctl = ctl_r;
    assign o_saving = saving_r;

    property p_entry;
        @(posedge i_clk) disable iff (i_srst)
        (!edge_w)[*8] ##0 (idle_r == ENTRY_CYC) |-> ##1 saving_r;
    endproperty
    a_entry: assert property (p_entry) else $error("no save entry");

    property p_off;
        @(posedge i_clk) disable iff (i_srst)
        saving_r |-> (o_ctl.ch_power == CH_ALL_OFF) && o_ctl.filt_rst;
    endproperty
    a_off: assert property (p_off) else $error("channels not off");

    property p_wake;
        @(posedge i_clk) disable iff (i_srst)
        (state_r == MCS_SAVE) && edge_w |-> ##1 !saving_r
            && (o_ctl.ch_power == CH_ALL_ON);
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");

    sequence s_wake;
        (state_r == MCS_SAVE) && edge_w;
    endsequence
    property p_vol;
        @(posedge i_clk) disable iff (i_srst)
        s_wake ##1 !i_vol_update |-> ##1 !o_ctl.vol_apply;
    endproperty
    a_vol: assert property (p_vol) else $error("volume early");

    property p_keep;
        @(posedge i_clk) disable iff (i_srst)
        saving_r |-> !o_ctl.vol_apply;
    endproperty
    a_keep: assert property (p_keep) else $error("volume in save");

    // Last idle cycle before the stop is declared
    sequence s_stop_due;
        !edge_w && (idle_r == ENTRY_CYC - CNT_ONE);
    endsequence

    // Waking without a volume write must not re-arm the volume
    sequence s_quiet_hold;
        (!i_vol_update && !saving_r)[*2];
    endsequence

    // Outside saving the converters run and filters are free
    property p_run_on;
        @(posedge i_clk) disable iff (i_srst)
        !saving_r |-> (o_ctl.ch_power == CH_ALL_ON) && !o_ctl.filt_rst;
    endproperty
    a_run_on: assert property (p_run_on) else $error("run not on");

    // Channel power is all or nothing, never a mix
    property p_pwr_two;
        @(posedge i_clk) disable iff (i_srst)
        (o_ctl.ch_power == CH_ALL_ON) || (o_ctl.ch_power == CH_ALL_OFF);
    endproperty
    a_pwr_two: assert property (p_pwr_two) else $error("mixed power");

    // A volume write while still saving is refused
    property p_refuse;
        @(posedge i_clk) disable iff (i_srst)
        (state_r == MCS_SAVE) && !edge_w && i_vol_update
            |-> ##1 saving_r && !o_ctl.vol_apply;
    endproperty
    a_refuse: assert property (p_refuse) else $error("write in save");

    // The host write after wake restores the volume
    property p_restore;
        @(posedge i_clk) disable iff (i_srst)
        (state_r == MCS_HOLDVOL) && i_vol_update
            && (edge_w || idle_r != ENTRY_CYC - CNT_ONE)
            |-> ##1 o_ctl.vol_apply;
    endproperty
    a_restore: assert property (p_restore) else $error("no restore");

    // A second stop before the volume write saves again
    property p_resave;
        @(posedge i_clk) disable iff (i_srst)
        (state_r == MCS_HOLDVOL) ##0 s_stop_due |-> ##1 saving_r;
    endproperty
    a_resave: assert property (p_resave) else $error("no resave");

    // Two quiet cycles after wake keep the volume held
    property p_hold_vol;
        @(posedge i_clk) disable iff (i_srst)
        s_wake ##1 s_quiet_hold |-> !o_ctl.vol_apply;
    endproperty
    a_hold_vol: assert property (p_hold_vol) else $error("vol leak");

    // Any master clock activity restarts the idle time
    property p_idle_clr;
        @(posedge i_clk) disable iff (i_srst)
        edge_w |-> ##1 (idle_r == CNT_ZERO);
    endproperty
    a_idle_clr: assert property (p_idle_clr) else $error("idle kept");

    // Counter parks at the limit so it cannot wrap into a false wake
    property p_idle_sat;
        @(posedge i_clk) disable iff (i_srst)
        (idle_r == ENTRY_CYC) && !edge_w |-> ##1 (idle_r == ENTRY_CYC);
    endproperty
    a_idle_sat: assert property (p_idle_sat) else $error("idle wrap");

    // Idle count never passes the limit
    property p_idle_max;
        @(posedge i_clk) disable iff (i_srst)
        idle_r <= ENTRY_CYC;
    endproperty
    a_idle_max: assert property (p_idle_max) else $error("idle over");

    // Saving holds for as long as the master clock stays still
    property p_stay;
        @(posedge i_clk) disable iff (i_srst)
        saving_r && !edge_w |-> ##1 saving_r;
    endproperty
    a_stay: assert property (p_stay) else $error("save dropped");

    // Saving never starts before the full idle time
    property p_no_early;
        @(posedge i_clk) disable iff (i_srst)
        $rose(saving_r) |-> ($past(idle_r) == ENTRY_CYC - CNT_ONE);
    endproperty
    a_no_early: assert property (p_no_early) else $error("early save");

    // Only the three coded states occur
    property p_state_ok;
        @(posedge i_clk) disable iff (i_srst)
        (state_r == MCS_RUN) || (state_r == MCS_SAVE)
            || (state_r == MCS_HOLDVOL);
    endproperty
    a_state_ok: assert property (p_state_ok) else $error("bad state");
endmodule
`default_nettype wire

// ==== src/mcs_pkg.sv ====
// What this block does
// - Enter power saving once the master clock has not toggled for a time between 2 us and 10 us, a period beyond 1000 ns.
// - While power saving, all converter channels are powered down and the interpolation filters held in reset.
// - Control registers keep their contents and stay readable and writable while power saving. A volume-update write while saving is ignored here.
// - When the master clock restarts, the converters power up on their own within 0.5 to 1 master clock cycle.
// - After power saving, stored volume is not reapplied until the host writes the volume-update bit.
package mcs_pkg;
    // Reference clock rate and supervision times
    localparam int CLK_MHZ = 40;
    localparam int SAVE_ENTRY_NS = 2000;
    localparam int SAVE_ENTRY_CYC = (SAVE_ENTRY_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [CNT_W-1:0] ENTRY_LIMIT = CNT_W'(SAVE_ENTRY_CYC);
    localparam int NUM_CH = 8;
    localparam logic [NUM_CH-1:0] CH_ALL_ON = 8'hff;
    localparam logic [NUM_CH-1:0] CH_ALL_OFF = 8'h00;

    typedef enum logic [1:0] {
        MCS_RUN = 2'b00,
        MCS_SAVE = 2'b01,
        MCS_HOLDVOL = 2'b10
    } mcs_state_t;

    // Outputs that steer the converter datapath
    typedef struct packed {
        logic [NUM_CH-1:0] ch_power;
        logic filt_rst;
        logic vol_apply;
    } mcs_ctl_t;
endpackage

// ==== src/mcs_edge.sv ====
`timescale 1ns/1ps
`default_nettype none
// Edge detector on the sampled master clock level
module mcs_edge
    import mcs_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Sampled level and its edge
    input wire logic i_lvl,
    output logic o_edge
);
    logic lvl_r;
    logic lvl_nxt;

    // Any transition counts as activity
    always_comb begin
        lvl_nxt = i_lvl;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            lvl_r <= 1'b0;
        end else begin
            lvl_r <= lvl_nxt;
        end
    end

    assign o_edge = lvl_r ^ i_lvl;
endmodule
`default_nettype wire

// ==== tb/mcs_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Host side: master clock with random phases, parked low when stopped
module mcs_host_model (
    input wire logic i_clk,
    input wire logic i_run,
    output logic o_mclk
);
    int hold = 0;
    initial o_mclk = 1'b0;
    // Phases of 1 to 3 cycles keep the period far below 1000 ns
    always @(posedge i_clk) begin
        if (!i_run) begin
            o_mclk <= #1 1'b0;
        end else if (hold == 0) begin
            o_mclk <= #1 ~o_mclk;
            hold = $urandom_range(2, 0);
        end else begin
            hold = hold - 1;
        end
    end
endmodule
`default_nettype wire

// ==== tb/master_clock_loss_powersave_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module master_clock_loss_powersave_bench;
    import mcs_pkg::*;
    localparam logic [CNT_W-1:0] ENTRY = 8'h08;
    localparam logic [10:0] RUN = {1'b0, CH_ALL_ON, 2'b01};
    localparam logic [10:0] SAVE = {1'b1, CH_ALL_OFF, 2'b10};
    localparam logic [10:0] WAKE = {1'b0, CH_ALL_ON, 2'b00};
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic run = 1'b0;
    logic vol_upd = 1'b0;
    logic mclk;
    mcs_ctl_t o_ctl;
    logic o_saving;
    logic [10:0] note_q[$];
    int error_cnt = 0;
    int comparisons = 0;
    int cyc = 0;
    int n;
    always #12.5 i_clk = ~i_clk;
    mcs_host_model host (.i_clk(i_clk), .i_run(run), .o_mclk(mclk));
    mcs_top #(.ENTRY_CYC(ENTRY)) dut (.i_clk(i_clk), .i_srst(i_srst),
        .i_mclk(mclk), .i_vol_update(vol_upd), .o_ctl(o_ctl),
        .o_saving(o_saving));
    task automatic cmp(input logic [10:0] got, input logic [10:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask
    // Wait for the saving flag to reach a level, bounded
    task automatic wait_saving(input logic lvl);
        n = 0;
        while (o_saving !== lvl && n < 40) begin
            step(1);
            n++;
        end
    endtask
    // Watcher: oldest note against settled outputs mid-cycle
    always @(negedge i_clk) begin
        if (note_q.size() > 0) cmp({o_saving, o_ctl}, note_q.pop_front());
    end
    // Hang guard, far above the hundred or so cycles needed
    always @(posedge i_clk) begin
        cyc++;
        if (cyc > 2000) begin
            error_cnt++;
            give_verdict();
        end
    end
    initial begin
        void'($urandom(32'h37dc));
        step(2);
        i_srst = 1'b0;
        run = 1'b1;
        step(20);
        run = 1'b0;
        step(3);
        run = 1'b1;
        note_q.push_back(RUN);
        step(10);
        run = 1'b0;
        n = 0;
        while (o_saving !== 1'b1 && n < 40) begin
            step(1);
            n++;
        end
        cmp(11'(n >= ENTRY - 3 && n <= ENTRY + 4), 11'h1);
        note_q.push_back(SAVE);
        vol_upd = 1'b1;
        step(1);
        vol_upd = 1'b0;
        note_q.push_back(SAVE);
        step(5);
        note_q.push_back(SAVE);
        run = 1'b1;
        n = 0;
        while (o_saving !== 1'b0 && n < 40) begin
            step(1);
            n++;
        end
        cmp(11'(n <= 4), 11'h1);
        note_q.push_back(WAKE);
        step(6);
        note_q.push_back(WAKE);
        vol_upd = 1'b1;
        step(1);
        vol_upd = 1'b0;
        note_q.push_back(RUN);
        step(2);
        // Stop, wake, then stop again before any volume write
        run = 1'b0;
        wait_saving(1'b1);
        note_q.push_back(SAVE);
        run = 1'b1;
        wait_saving(1'b0);
        cmp(11'(n <= 4), 11'h1);
        note_q.push_back(WAKE);
        step(3);
        run = 1'b0;
        wait_saving(1'b1);
        cmp(11'(n >= ENTRY - 3 && n <= ENTRY + 4), 11'h1);
        note_q.push_back(SAVE);
        step(2);
        // Reset in mid-run while saving brings back normal outputs
        i_srst = 1'b1;
        step(2);
        i_srst = 1'b0;
        note_q.push_back(RUN);
        step(2);
        give_verdict();
    end
endmodule
`default_nettype wire
